//--- src/lcd_pin_config.sv
// LCD driver output pin configuration: shadow/active registers, pin role mux, general outputs
`timescale 1ns/1ns

// Overview of operation
// (RULE1) Duty code 00: quarter duty, four commons
// (RULE2) Duty code 01: third duty, fourth common segment
// (RULE3) Duty code 10: half duty, two commons
// (RULE4) Duty code 11: static, one common only
// (RULE5) Last segment grounded unless enabled
// (RULE6) Port code picks shared pins as outputs
// (RULE7) Static, all segments: data drives segments 1-28
// (RULE8) Static, three outputs: data drives segments 4-28
// (RULE9) Plain general output follows same-index data bit
// (RULE10) First output: plain, clock or pulse
// (RULE11) Second, third outputs: plain or pulse
// (RULE12) Host zeroes unused function and pulse fields
// (RULE13) Static mode offers 25 or 28 segments
// (RULE14) Function 00 plain; 11 on first is pulse
// (RULE15) New settings apply together after full transfer
module lcd_pin_config (
  input  wire logic                           i_clk,
  input  wire logic                           i_rstn,
  input  wire logic [lcd_pin_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [lcd_pin_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  output logic      [lcd_pin_pkg::DATA_W-1:0] o_rdata,
  output lcd_pin_pkg::duty_mode_t             o_duty_mode,
  output logic                                o_bias_half,
  output logic      [3:0]                     o_com_active,
  output logic      [lcd_pin_pkg::NUM_SEG-1:0] o_seg_active,
  output logic      [lcd_pin_pkg::NUM_SEG-1:0] o_seg_level,
  output logic      [3:0]                     o_gpo_active,
  output logic      [3:0]                     o_gpo_level,
  output logic      [4:0]                     o_seg_count
);
  import lcd_pin_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Shared pins taken as general outputs, bit 0 is the first shared pin
  function automatic logic [3:0] shared_gpo_mask(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h0;
    unique case (code)
      3'b001:  m = 4'h1;
      3'b010:  m = 4'h3;
      3'b011:  m = 4'h7;
      3'b100:  m = 4'hf;
      default: m = 4'h0;
    endcase
    return m;
  endfunction : shared_gpo_mask

  // Common pins kept as commons for a duty code
  function automatic logic [3:0] common_mask(input duty_mode_t d);
    logic [3:0] m;
    m = 4'h1;
    unique case (d)
      DUTY_QUARTER: m = 4'hf;
      DUTY_THIRD:   m = 4'h7;
      DUTY_HALF:    m = 4'h3;
      DUTY_STATIC:  m = 4'h1;
    endcase
    return m;
  endfunction : common_mask

  function automatic logic [4:0] count_ones(input logic [NUM_SEG-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < NUM_SEG; k++) begin
      n = n + {4'h0, v[k]};
    end
    return n;
  endfunction : count_ones

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow registers, written one word at a time by the host

  logic [NUM_SEG-1:0]   sh_display_r;
  logic [CFG_W-1:0]     sh_config_r;
  logic [3*PULSE_W-1:0] sh_duty_r;
  logic [RATE_W-1:0]    sh_rate_r;
  logic                 pending_r;

  logic wr_display;
  logic wr_config;
  logic wr_duty;
  logic wr_rate;
  logic commit;

  assign wr_display = i_wr && (i_addr == OFF_DISPLAY);
  assign wr_config  = i_wr && (i_addr == OFF_CONFIG);
  assign wr_duty    = i_wr && (i_addr == OFF_PULSE_DUTY);
  assign wr_rate    = i_wr && (i_addr == OFF_PULSE_RATE);
  assign commit     = i_wr && (i_addr == OFF_COMMIT);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_display_r <= DISPLAY_RESET;
      sh_config_r  <= CONFIG_RESET;
      sh_duty_r    <= DUTY_RESET;
      sh_rate_r    <= RATE_RESET;
    end else begin
      if (wr_display) begin
        sh_display_r <= i_wdata[NUM_SEG-1:0];
      end
      if (wr_config) begin
        sh_config_r <= i_wdata[CFG_W-1:0];
      end
      if (wr_duty) begin
        sh_duty_r <= i_wdata[3*PULSE_W-1:0];
      end
      if (wr_rate) begin
        sh_rate_r <= i_wdata[RATE_W-1:0];
      end
    end
  end

  // Pending shows shadow content not yet applied
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pending_r <= 1'b0;
    end else if (wr_display || wr_config || wr_duty || wr_rate) begin
      pending_r <= 1'b1;
    end else if (commit) begin
      pending_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Active registers: the whole set moves at once, so pins never show a half-loaded mix

  logic [NUM_SEG-1:0]   act_display_r;
  logic [CFG_W-1:0]     act_config_r;
  logic [3*PULSE_W-1:0] act_duty_r;
  logic [RATE_W-1:0]    act_rate_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      act_display_r <= DISPLAY_RESET;
      act_config_r  <= CONFIG_RESET;
      act_duty_r    <= DUTY_RESET;
      act_rate_r    <= RATE_RESET;
    end else if (commit) begin // [RULE15]
      act_display_r <= sh_display_r;
      act_config_r  <= sh_config_r;
      act_duty_r    <= sh_duty_r;
      act_rate_r    <= sh_rate_r;
    end
  end

  duty_mode_t  act_duty_mode;
  logic        act_last_seg;
  logic [2:0]  act_port_code;
  logic [7:0]  act_func;

  assign act_duty_mode = duty_mode_t'(act_config_r[CFG_DUTY_LSB +: 2]);
  assign act_last_seg  = act_config_r[CFG_LAST_SEG];
  assign act_port_code = act_config_r[CFG_PORT_LSB +: 3];
  assign act_func      = act_config_r[CFG_FUNC_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse step divider and channels

  logic [19:0] rate_cnt_r;
  logic [19:0] rate_limit;
  logic        step;
  logic        clk_out_r;
  logic [2:0]  pulse;

  assign rate_limit = 20'(({16'h0000, act_rate_r} + 20'h00001) * {4'h0, RATE_BASE_CYCLES}) - 20'h00001;
  assign step       = (rate_cnt_r >= rate_limit);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rate_cnt_r <= '0;
    end else if (step) begin
      rate_cnt_r <= '0;
    end else begin
      rate_cnt_r <= rate_cnt_r + 20'h00001;
    end
  end

  // Clock output runs at half the step rate
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_out_r <= 1'b0;
    end else if (step) begin
      clk_out_r <= ~clk_out_r;
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_pulse
    pulse_channel u_chan (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_step  (step),
      .i_duty  (act_duty_r[c*PULSE_W +: PULSE_W]),
      .o_pulse (pulse[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin role mux

  logic [3:0]         gpo_mask;
  logic [3:0]         com_mask;
  logic [NUM_SEG-1:0] seg_active_nxt;
  logic [3:0]         gpo_level_nxt;

  assign gpo_mask = shared_gpo_mask(act_port_code); // [RULE6]
  assign com_mask = common_mask(act_duty_mode); // [RULE1] [RULE2] [RULE3] [RULE4]

  always_comb begin
    seg_active_nxt        = '1;
    seg_active_nxt[3:0]   = ~gpo_mask; // [RULE6] [RULE13]
    seg_active_nxt[24]    = ~com_mask[3];
    seg_active_nxt[25]    = ~com_mask[2];
    seg_active_nxt[26]    = ~com_mask[1];
    seg_active_nxt[27]    = act_last_seg; // [RULE5]
  end

  // Function field per output; unused codes on the first output fall back to plain level
  always_comb begin
    gpo_level_nxt = 4'h0;
    for (int k = 0; k < 4; k++) begin
      logic [1:0] f;
      f = act_func[2*k +: 2];
      if (!gpo_mask[k]) begin
        gpo_level_nxt[k] = 1'b0;
      end else if (f == FUNC_PLAIN) begin
        gpo_level_nxt[k] = act_display_r[k]; // [RULE9] [RULE14]
      end else if (k == 0) begin
        if (f == FUNC_CLOCK) begin
          gpo_level_nxt[k] = clk_out_r; // [RULE10]
        end else if (f == FUNC_PWM_A) begin
          gpo_level_nxt[k] = pulse[0]; // [RULE10] [RULE14]
        end else begin
          gpo_level_nxt[k] = act_display_r[k];
        end
      end else begin
        gpo_level_nxt[k] = pulse[f - 2'h1]; // [RULE11]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_duty_mode  <= DUTY_QUARTER;
      o_bias_half  <= 1'b0;
      o_com_active <= 4'hf;
      o_seg_active <= '0;
      o_seg_level  <= '0;
      o_gpo_active <= 4'h0;
      o_gpo_level  <= 4'h0;
      o_seg_count  <= 5'h00;
    end else begin
      o_duty_mode  <= act_duty_mode;
      o_bias_half  <= (act_duty_mode == DUTY_HALF); // [RULE3]
      o_com_active <= com_mask;
      o_seg_active <= seg_active_nxt;
      o_seg_level  <= act_display_r & seg_active_nxt; // [RULE7] [RULE8]
      o_gpo_active <= gpo_mask;
      o_gpo_level  <= gpo_level_nxt;
      o_seg_count  <= count_ones(seg_active_nxt); // [RULE13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port: data one cycle after the strobe, unmapped reads give zero

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        OFF_DISPLAY:    o_rdata <= {4'h0, sh_display_r};
        OFF_CONFIG:     o_rdata <= {16'h0000, sh_config_r};
        OFF_PULSE_DUTY: o_rdata <= {14'h0000, sh_duty_r};
        OFF_PULSE_RATE: o_rdata <= {28'h0000000, sh_rate_r};
        OFF_ACTIVE_CFG: o_rdata <= {16'h0000, act_config_r};
        OFF_STATUS:     o_rdata <= {23'h000000, pending_r, 3'h0, count_ones(seg_active_nxt)};
        default:        o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_commit;
    i_wr && (i_addr == OFF_COMMIT);
  endsequence

  sequence s_no_commit;
    !(i_wr && (i_addr == OFF_COMMIT));
  endsequence

  a_quarter_commons: assert property (o_duty_mode == DUTY_QUARTER |-> o_com_active == 4'hf && !o_bias_half) // [RULE1]
    else $error("quarter duty must drive all four commons");

  a_third_commons: assert property (o_duty_mode == DUTY_THIRD |-> o_com_active == 4'h7 && o_seg_active[24]) // [RULE2]
    else $error("third duty must turn fourth common into segment 25");

  a_half_commons: assert property (o_duty_mode == DUTY_HALF // [RULE3]
                                   |-> o_com_active == 4'h3 && o_bias_half && o_seg_active[25] && o_seg_active[24])
    else $error("half duty must turn commons three and four into segments");

  a_static_commons: assert property (o_duty_mode == DUTY_STATIC // [RULE4]
                                     |-> o_com_active == 4'h1 && (&o_seg_active[26:24]))
    else $error("static mode must keep only the first common");

  a_last_ground: assert property (o_seg_active[27] == $past(act_last_seg) // [RULE5]
                                  && (o_seg_active[27] || !o_seg_level[27]))
    else $error("last segment pin not grounded when disabled");

  // Outputs other than the commons sit low in reset, so roles only agree once a clean cycle has passed
  a_port_map: assert property ($past(i_rstn) |-> o_gpo_active == shared_gpo_mask($past(act_port_code)) // [RULE6]
                               && o_seg_active[3:0] == ~o_gpo_active)
    else $error("shared pin roles do not follow port code");

  a_static_segs: assert property (o_duty_mode == DUTY_STATIC && o_gpo_active == 4'h0 // [RULE7] [RULE13]
                                  && o_seg_active[27] |-> o_seg_level == $past(act_display_r) && o_seg_count == 5'h1c)
    else $error("static all-segment data mismatch");

  a_three_gpo: assert property (o_duty_mode == DUTY_STATIC && o_gpo_active == 4'h7 // [RULE8] [RULE13]
                                && o_seg_active[27]
                                |-> o_seg_level[27:3] == $past(act_display_r[27:3]) && o_seg_count == 5'h19)
    else $error("static three-output data mismatch");

  a_plain_level: assert property (act_port_code == 3'b100 && act_func[1:0] == FUNC_PLAIN // [RULE9] [RULE14]
                                  ##1 $stable(act_config_r) |-> o_gpo_level[0] == $past(act_display_r[0]))
    else $error("plain output does not follow data bit");

  a_commit_apply: assert property (s_commit |-> ##1 act_config_r == $past(sh_config_r) // [RULE15]
                                   ##1 o_duty_mode == duty_mode_t'($past(sh_config_r[CFG_DUTY_LSB +: 2], 2)))
    else $error("committed settings did not reach the pins");

  a_active_hold: assert property (s_no_commit |=> $stable(act_display_r) && $stable(act_config_r)) // [RULE15]
    else $error("active settings changed without a commit");

endmodule : lcd_pin_config

//--- src/lcd_pin_pkg.sv
// Package: register map, field layout, codes and reset values of the LCD output pin configuration block
package lcd_pin_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SEG = 28;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_DISPLAY    = 8'h00;
  localparam logic [7:0] OFF_CONFIG     = 8'h04;
  localparam logic [7:0] OFF_PULSE_DUTY = 8'h08;
  localparam logic [7:0] OFF_PULSE_RATE = 8'h0c;
  localparam logic [7:0] OFF_COMMIT     = 8'h10;
  localparam logic [7:0] OFF_ACTIVE_CFG = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration word layout
  localparam int CFG_DUTY_LSB  = 0;
  localparam int CFG_LAST_SEG  = 2;
  localparam int CFG_PORT_LSB  = 3;
  localparam int CFG_FUNC_LSB  = 8;
  localparam int CFG_W         = 16;
  localparam int PULSE_W       = 6;
  localparam int RATE_W        = 4;
  localparam int STAT_PEND_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [27:0]     DISPLAY_RESET = 28'h0000000;
  localparam logic [15:0]     CONFIG_RESET  = 16'h0000;
  localparam logic [17:0]     DUTY_RESET    = 18'h00000;
  localparam logic [3:0]      RATE_RESET    = 4'h0;

  // Pulse step period is (rate + 1) times this many clocks
  localparam logic [15:0] RATE_BASE_CYCLES = 16'h0010;

  ////////////////////////////////////////////////////////////////////////////////
  // Codes
  typedef enum logic [1:0] {
    DUTY_QUARTER = 2'b00,
    DUTY_THIRD   = 2'b01,
    DUTY_HALF    = 2'b10,
    DUTY_STATIC  = 2'b11
  } duty_mode_t;

  localparam logic [1:0] FUNC_PLAIN = 2'b00;
  localparam logic [1:0] FUNC_CLOCK = 2'b01;
  localparam logic [1:0] FUNC_PWM_A = 2'b11;

endpackage : lcd_pin_pkg

//--- src/pulse_channel.sv
// Pulse-width channel: 64-step counter compared against a 6-bit duty
`timescale 1ns/1ns
module pulse_channel (
  input  wire logic                            i_clk,
  input  wire logic                            i_rstn,
  input  wire logic                            i_step,
  input  wire logic [lcd_pin_pkg::PULSE_W-1:0] i_duty,
  output logic                                 o_pulse
);
  import lcd_pin_pkg::*;

  logic [PULSE_W-1:0] count_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_r <= '0;
    end else if (i_step) begin
      count_r <= count_r + 6'h01;
    end
  end

  // High for duty+1 of 64 steps, so all ones is fully on
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= (count_r <= i_duty);
    end
  end

endmodule : pulse_channel

//--- verification/host_ctrl_model.sv
// Host controller model: drives the register port and loads whole configurations
`timescale 1ns/1ns
module host_ctrl_model (
  input  wire logic                           i_clk,
  input  wire logic [lcd_pin_pkg::DATA_W-1:0] i_rdata,
  output logic      [lcd_pin_pkg::ADDR_W-1:0] o_addr,
  output logic      [lcd_pin_pkg::DATA_W-1:0] o_wdata,
  output logic                                o_wr,
  output logic                                o_rd
);
  import lcd_pin_pkg::*;

  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h00000000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    // Released data never keeps its last value
    o_wdata <= ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : read

  ////////////////////////////////////////////////////////////////////////////////
  // Shadows first, commit last so pins switch in one step
  task automatic load(input logic [27:0] data, input logic [15:0] cfg, input logic [17:0] duty,
                      input logic [3:0] rate);
    int          n;
    logic [15:0] c;
    logic [17:0] w;
    logic [3:0]  r;
    n = (cfg[5:3] <= 3'd4) ? int'(cfg[5:3]) : 0;
    c = cfg;
    w = duty;
    r = rate;
    for (int k = n; k < 4; k++) begin
      c[8+2*k +: 2] = 2'b00;
    end
    if (n == 0) begin
      w = 18'h00000;
      r = 4'h0;
    end
    write(OFF_DISPLAY, {4'h0, data});
    write(OFF_CONFIG, {16'h0000, c});
    write(OFF_PULSE_DUTY, {14'h0000, w});
    write(OFF_PULSE_RATE, {28'h0000000, r});
    write(OFF_COMMIT, 32'h00000000);
  endtask : load
endmodule : host_ctrl_model

//--- verification/lcd_driver_output_pin_config_test.sv
// Testbench for the LCD output pin configuration block
`timescale 1ns/1ns
module lcd_driver_output_pin_config_test;
  import lcd_pin_pkg::*;

  logic              clk;
  logic              rstn;
  logic [7:0]        addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  duty_mode_t        duty_mode;
  logic              bias_half;
  logic [3:0]        com_active;
  logic [27:0]       seg_active;
  logic [27:0]       seg_level;
  logic [3:0]        gpo_active;
  logic [3:0]        gpo_level;
  logic [4:0]        seg_count;
  int                mismatches;
  int                total_checks;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  host_ctrl_model i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

  lcd_pin_config i_dut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_duty_mode(duty_mode), .o_bias_half(bias_half), .o_com_active(com_active),
    .o_seg_active(seg_active), .o_seg_level(seg_level), .o_gpo_active(gpo_active),
    .o_gpo_level(gpo_level), .o_seg_count(seg_count));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Pins follow the commit two edges later
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic check_pins(input logic [27:0] data, input logic [15:0] cfg);
    int          n;
    logic [1:0]  d;
    logic [27:0] s;
    logic [3:0]  g;
    d = cfg[1:0];
    n = (cfg[5:3] <= 3'd4) ? int'(cfg[5:3]) : 0;
    s = 28'h0ffffff & ~((28'h0000001 << n) - 28'h0000001);
    s[24] = (d != 2'b00);
    s[25] = (d[1] == 1'b1);
    s[26] = (d == 2'b11);
    s[27] = cfg[2];
    g = 4'((5'h01 << n) - 5'h01);
    chk(32'(duty_mode), 32'(d));
    chk(32'(bias_half), 32'(d == 2'b10));
    chk(32'(com_active), 32'(4'hf >> d));
    chk(32'(seg_active), 32'(s));
    chk(32'(seg_level), 32'(data & s));
    chk(32'(gpo_active), 32'(g));
    chk(32'(gpo_level), 32'(data[3:0] & g));
    chk(32'(seg_count), 32'($countones(s)));
  endtask : check_pins

  ////////////////////////////////////////////////////////////////////////////////
  // Every duty, port code and last-segment setting
  task automatic all_layouts;
    logic [15:0] cfg;
    logic [27:0] data;
    for (int i = 0; i < 64; i++) begin
      cfg = {10'h000, 6'(i)};
      data = i[0] ? 28'h5a3c96f : 28'ha5c3690;
      i_host.load(data, cfg, 18'h00000, 4'h0);
      settle();
      check_pins(data, cfg);
    end
  endtask : all_layouts

  // Shadow writes stay hidden until commit; bus reads, refused writes, unmapped place
  task automatic shadow_and_bus;
    logic [31:0] v;
    i_host.load(28'hfffffff, 16'h0007, 18'h00000, 4'h0);
    settle();
    check_pins(28'hfffffff, 16'h0007);
    i_host.write(OFF_CONFIG, 32'h00000020);
    i_host.write(OFF_DISPLAY, 32'h00000000);
    repeat (3) @(posedge clk);
    #1;
    check_pins(28'hfffffff, 16'h0007);
    i_host.read(OFF_STATUS, v);
    chk(v, 32'h0000011c);
    i_host.read(OFF_CONFIG, v);
    chk(v, 32'h00000020);
    i_host.write(OFF_ACTIVE_CFG, 32'h0000ffff);
    i_host.read(OFF_ACTIVE_CFG, v);
    chk(v, 32'h00000007);
    i_host.read(8'h20, v);
    chk(v, 32'h00000000);
    @(posedge clk);
    #1;
    chk(rdata, 32'h00000000);
    i_host.write(OFF_COMMIT, 32'h00000000);
    settle();
    check_pins(28'h0000000, 16'h0020);
    i_host.read(OFF_STATUS, v);
    chk(v, 32'h00000014);
  endtask : shadow_and_bus

  // General output functions over one full pulse period of 1024 clocks
  task automatic out_functions(input logic [15:0] cfg, input logic [17:0] duty, input logic [27:0] data,
                               input int exp_tog, input int e0, input int e1, input int e2, input int e3);
    int   tog;
    int   h[4];
    logic prev;
    i_host.load(data, cfg, duty, 4'h0);
    settle();
    tog = 0;
    h = '{0, 0, 0, 0};
    prev = gpo_level[0];
    repeat (1024) begin
      @(posedge clk);
      #1;
      tog += (gpo_level[0] !== prev) ? 1 : 0;
      prev = gpo_level[0];
      for (int k = 0; k < 4; k++) begin
        h[k] += (gpo_level[k] === 1'b1) ? 1 : 0;
      end
    end
    chk(32'(tog), 32'(exp_tog));
    chk(32'(h[0]), 32'(e0));
    chk(32'(h[1]), 32'(e1));
    chk(32'(h[2]), 32'(e2));
    chk(32'(h[3]), 32'(e3));
  endtask : out_functions

  ////////////////////////////////////////////////////////////////////////////////
  // A hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    mismatches = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    settle();
    check_pins(28'h0000000, 16'h0000);
    all_layouts();
    shadow_and_bus();
    out_functions(16'hc923, 18'h00fc0, 28'h0000004, 64, 512, 1024, 1024, 16);
    out_functions(16'h3723, 18'h3f01f, 28'h0000008, 2, 512, 512, 1024, 1024);
    // Spare first-output code falls back to plain level
    out_functions(16'h6e23, 18'h3f3c0, 28'h0000001, 0, 1024, 1024, 256, 16);
    report_and_stop();
  end
endmodule : lcd_driver_output_pin_config_test
